// file: verilog/kwhr_top.sv
// top of the key wakeup halt release block with its register port
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - release pin and four keys release halt
// R2 - one enable bit per key pin
// R3 - write-only enable register, bits 7..4, reset zero
// R4 - enabled low key starts release
// R5 - halt entered only by software control write
// R6 - pending release at entry skips halt
// R7 - software checks enabled keys high first
// R8 - key pin levels readable through port data
// R9 - level style high pin, edge style rising
// R10 - edge style: keys disabled or held high
// R11 - release pin held low with keys
// R12 - key pins configured as inputs first
// R13 - wake pin never analog input
// R14 - or of keys with pin, clockless; the code ors the keys in only in level style
module kwhr_top #(
    parameter int WARM_CYCLES = kwhr_pkg::WARM_CYC // warm-up length in cycles
) (
    input wire logic CLK_SYS, // 50 MHz system clock
    input wire logic SYS_RST, // async reset, active high
    input wire logic [7:0] ADDR, // register address
    input wire logic [7:0] WDATA, // write data
    input wire logic WR, // write strobe
    input wire logic RD, // read strobe
    output logic [7:0] RDATA, // read data, cycle after the strobe
    input wire logic REL_PIN, // dedicated release pin
    input wire logic [3:0] KEY_PINS, // key wake pins 5..2 as bits 3..0
    output logic HALTED, // core clock stopped
    output logic WARMING, // warm-up in progress
    output logic WAKE_REQ // raw release request, no clock needed
);
    // ****************************************************************
    // bus decode
    // ****************************************************************
    kwhr_pkg::kwhr_bus_t bus; // bundled request
    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
    // writes land only at the enable and control offsets; all others are dropped
    wire wr_en = bus.wr && bus.addr == kwhr_pkg::KEY_WAKE_ENABLE_ADDR; // enable write
    wire wr_ctrl = bus.wr && bus.addr == kwhr_pkg::HALT_CTRL_ADDR; // control write
    // ****************************************************************
    // registers
    // ****************************************************************
    // the enables cannot be read back, so software must keep its own copy
    logic [3:0] key_en_reg; // key enables
    logic level_reg; // release style
    logic rel_past_reg; // release pin delayed for edge style
    logic [7:0] rdata_reg; // read data
    kwhr_pkg::kwhr_state_t state_reg, state_next; // halt sequencer
    logic [15:0] warm_cnt_reg, warm_cnt_next; // warm-up counter
    logic key_req; // any enabled key low
    logic rel_req; // combined release request

    // release detection is pure logic, so it works with the clock stopped
    // limitation: the edge-style detector still leans on one flop, so a pin
    // that falls and rises again between two clock edges is missed
    kwhr_detect u_detect (
        .key_pins(KEY_PINS),
        .key_en(key_en_reg),
        .rel_pin(REL_PIN),
        .rel_pin_past(rel_past_reg),
        .level_style(level_reg),
        .key_req(key_req),
        .rel_req(rel_req)
    );
    assign WAKE_REQ = rel_req; // [R14]

    // at entry the level check covers pin high or enabled key low
    // the style bit is ignored here on purpose: a high pin blocks entry in
    // both styles, and so does any enabled key held low
    wire entry_block = REL_PIN | key_req; // [R6]
    wire halt_cmd = wr_ctrl && bus.wdata[kwhr_pkg::CTRL_HALT_BIT]; // [R5]

    // enable and style registers; write-only enables [R2] [R3]
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            key_en_reg <= kwhr_pkg::KEY_EN_RESET; // [R3]
            level_reg <= kwhr_pkg::KEY_LEVEL_RESET;
            rel_past_reg <= 1'b0;
        end else begin
            // the low nibble of an enable write is don't-care and dropped
            if (wr_en) begin
                key_en_reg <= bus.wdata[kwhr_pkg::KEY_EN_LSB +: kwhr_pkg::KEY_NUM]; // [R3]
            end
            // the halt bit is a command and is not stored; only the style is kept
            if (wr_ctrl) begin
                level_reg <= bus.wdata[kwhr_pkg::CTRL_LEVEL_BIT];
            end
            // past copy of the release pin feeds the edge-style detector
            rel_past_reg <= REL_PIN;
        end
    end

    // ****************************************************************
    // halt sequencer
    // ****************************************************************
    // one-hot run, halt and warm states; a halt write outside run is ignored
    always_comb begin
        state_next = state_reg;
        warm_cnt_next = warm_cnt_reg;
        case (state_reg)
            kwhr_pkg::KWHR_RUN: begin
                if (halt_cmd) begin
                    // a pending release skips the halt entirely
                    state_next = entry_block ? kwhr_pkg::KWHR_WARM : kwhr_pkg::KWHR_HALT; // [R6]
                    warm_cnt_next = 16'(WARM_CYCLES - 1);
                end
            end
            kwhr_pkg::KWHR_HALT: begin
                if (rel_req) begin
                    state_next = kwhr_pkg::KWHR_WARM; // [R1] [R4] [R9]
                    warm_cnt_next = 16'(WARM_CYCLES - 1);
                end
            end
            kwhr_pkg::KWHR_WARM: begin
                // count down to zero, then hand back to run
                if (warm_cnt_reg == 16'h0000) begin
                    state_next = kwhr_pkg::KWHR_RUN;
                end else begin
                    warm_cnt_next = warm_cnt_reg - 16'h0001;
                end
            end
            default: begin
                // illegal code: recover to run rather than lock up
                state_next = kwhr_pkg::KWHR_RUN;
            end
        endcase
    end

    // state flops
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg <= kwhr_pkg::KWHR_RUN;
            warm_cnt_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            warm_cnt_reg <= warm_cnt_next;
        end
    end

    // status outputs decode straight from the one-hot state register
    assign HALTED = state_reg == kwhr_pkg::KWHR_HALT;
    assign WARMING = state_reg == kwhr_pkg::KWHR_WARM;

    // ****************************************************************
    // read path
    // ****************************************************************
    // enable register reads zero since it is write only; pins read live [R8]
    // unmapped offsets read zero as well
    wire [7:0] rd_mux =
        (bus.addr == kwhr_pkg::KEY_PORT_DATA_ADDR) ? {4'h0, KEY_PINS} :
        (bus.addr == kwhr_pkg::HALT_CTRL_ADDR) ? {6'h00, level_reg, 1'b0} :
        (bus.addr == kwhr_pkg::HALT_STAT_ADDR) ? {6'h00, WARMING, HALTED} :
        8'h00;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= bus.rd ? rd_mux : 8'h00; // [R8]
        end
    end
    assign RDATA = rdata_reg;

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_halt_entry;
        state_reg == kwhr_pkg::KWHR_RUN && halt_cmd;
    endsequence

    property p_skip_halt;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        s_halt_entry and entry_block |=> WARMING;
    endproperty
    a_skip_halt: assert property (p_skip_halt) else $error("halt not skipped"); // [R6]

    property p_enter_halt;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        s_halt_entry and !entry_block |=> HALTED;
    endproperty
    a_enter_halt: assert property (p_enter_halt) else $error("halt not entered"); // [R5]

    property p_only_sw_halt;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !$past(HALTED) && HALTED |-> $past(halt_cmd);
    endproperty
    a_only_sw_halt: assert property (p_only_sw_halt) else $error("halt without command"); // [R5]

    property p_key_wake;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        HALTED && level_reg && |(key_en_reg & ~KEY_PINS) |=> WARMING;
    endproperty
    a_key_wake: assert property (p_key_wake) else $error("key did not wake"); // [R4]

    property p_pin_level;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        HALTED && level_reg && REL_PIN |=> WARMING;
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("pin level did not wake"); // [R9]

    property p_edge_keys_ignored;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        HALTED && !level_reg && !REL_PIN |=> HALTED;
    endproperty
    a_edge_keys_ignored: assert property (p_edge_keys_ignored) else $error("edge wake w/o edge"); // [R9]

    property p_enable_write;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        wr_en |=> key_en_reg == $past(WDATA[kwhr_pkg::KEY_EN_LSB +: kwhr_pkg::KEY_NUM]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable not stored"); // [R3]

    property p_disabled_key;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        key_en_reg == 4'h0 |-> !key_req;
    endproperty
    a_disabled_key: assert property (p_disabled_key) else $error("disabled key requests"); // [R2]

    property p_port_read;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        RD && ADDR == kwhr_pkg::KEY_PORT_DATA_ADDR |=> RDATA[3:0] == $past(KEY_PINS);
    endproperty
    a_port_read: assert property (p_port_read) else $error("pin levels misread"); // [R8]

    property p_wake_comb;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        level_reg && REL_PIN |-> WAKE_REQ;
    endproperty
    a_wake_comb: assert property (p_wake_comb) else $error("release request missing"); // [R14]

    property p_any_wake;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        HALTED && rel_req |=> WARMING;
    endproperty
    a_any_wake: assert property (p_any_wake) else $error("release ignored"); // [R1]

    // ****************************************************************
    // assertions: sequencing and read path
    // ****************************************************************
    // halted with nothing asking for release
    sequence s_halt_wait;
        HALTED && !rel_req;
    endsequence

    // last cycle of the warm-up count
    sequence s_warm_last;
        WARMING && warm_cnt_reg == 16'h0000;
    endsequence

    property p_halt_hold;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        s_halt_wait |=> HALTED;
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt left early"); // [R1]

    property p_warm_done;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        s_warm_last |=> !WARMING && !HALTED;
    endproperty
    a_warm_done: assert property (p_warm_done) else $error("warm-up did not end"); // [R6]

    // warm-up always loads its full length
    property p_warm_start;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        $rose(WARMING) |-> warm_cnt_reg == 16'(WARM_CYCLES - 1);
    endproperty
    a_warm_start: assert property (p_warm_start) else $error("warm-up too short"); // [R6]

    // edge style: only a fresh rise of the pin counts, keys never do
    property p_edge_form;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !level_reg |-> WAKE_REQ == (REL_PIN && !rel_past_reg);
    endproperty
    a_edge_form: assert property (p_edge_form) else $error("edge request wrong"); // [R9]

    // level style: pin high or any enabled key low
    property p_level_form;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        level_reg |-> WAKE_REQ == (REL_PIN || (|(key_en_reg & ~KEY_PINS)));
    endproperty
    a_level_form: assert property (p_level_form) else $error("level request wrong"); // [R14]

    // enables change only on a write to their offset
    property p_enable_hold;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !wr_en |=> $stable(key_en_reg);
    endproperty
    a_enable_hold: assert property (p_enable_hold) else $error("enables changed"); // [R2]

    property p_enable_zero_read;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        RD && ADDR == kwhr_pkg::KEY_WAKE_ENABLE_ADDR |=> RDATA == 8'h00;
    endproperty
    a_enable_zero_read: assert property (p_enable_zero_read) else $error("enables readable"); // [R3]

    // read data is zero outside the cycle after a read strobe
    property p_read_idle;
        @(posedge CLK_SYS) disable iff (SYS_RST)
        !RD |=> RDATA == 8'h00;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("stale read data"); // [R8]
endmodule : kwhr_top
`default_nettype wire

// file: verilog/kwhr_pkg.sv
// package: constants and types for the key wakeup halt release block
package kwhr_pkg;
    // register map
    localparam logic [7:0] KEY_WAKE_ENABLE_ADDR = 8'h31; // enable register, write only
    localparam logic [7:0] KEY_PORT_DATA_ADDR = 8'h32; // pin level readback
    localparam logic [7:0] HALT_CTRL_ADDR = 8'h33; // halt request and release style
    localparam logic [7:0] HALT_STAT_ADDR = 8'h34; // halt state readback
    // field positions
    localparam int KEY_EN_LSB = 4; // enable bits 7..4 map to pins 5..2
    localparam int KEY_NUM = 4; // number of key wake pins
    localparam int CTRL_HALT_BIT = 0; // write 1 requests halt entry
    localparam int CTRL_LEVEL_BIT = 1; // 1 level style, 0 edge style
    localparam int STAT_HALT_BIT = 0; // halted flag
    localparam int STAT_WARM_BIT = 1; // warm-up running flag
    // reset values
    localparam logic [3:0] KEY_EN_RESET = 4'h0;
    localparam logic KEY_LEVEL_RESET = 1'b0;
    // warm-up time and its cycle count at 50 MHz
    localparam int WARM_NS = 1000; // warm-up time in ns, plain default
    localparam int CLK_NS = 20;
    localparam int WARM_CYC = (WARM_NS + CLK_NS - 1) / CLK_NS;
    // halt sequencer states
    typedef enum logic [2:0] {
        KWHR_RUN = 3'b001,
        KWHR_HALT = 3'b010,
        KWHR_WARM = 3'b100
    } kwhr_state_t;
    // register bus request bundle
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } kwhr_bus_t;
endpackage : kwhr_pkg

// file: verilog/kwhr_detect.sv
// combinational release detector, needs no running clock
`timescale 1ns/1ps
`default_nettype none
module kwhr_detect (
    input wire logic [3:0] key_pins, // key wake pins 5..2 as bits 3..0
    input wire logic [3:0] key_en, // per-pin enables
    input wire logic rel_pin, // dedicated release pin
    input wire logic rel_pin_past, // release pin one cycle earlier
    input wire logic level_style, // 1 level style, 0 edge style
    output logic key_req, // any enabled key low
    output logic rel_req // combined release request
);
    // key request: or of enabled, low pins [R14] [R4]
    assign key_req = |(key_en & ~key_pins);
    // release pin: high level or rising edge by style [R9]
    wire pin_req = level_style ? rel_pin : (rel_pin & ~rel_pin_past);
    // keys only release in level style; edge style leaves them out of rel_req [R9]
    assign rel_req = pin_req | (level_style & key_req); // [R1] [R14]
endmodule : kwhr_detect
`default_nettype wire

// file: sim/kwhr_keys.sv
// key switch and release source model for the halt release bench
`timescale 1ns/1ps
`default_nettype none
module kwhr_keys #(
    parameter int SETTLE_NS = 0 // contact settling delay, 0 answers at once
) (
    input wire logic [3:0] press, // key held down, one bit per key wake pin
    input wire logic rel_on, // release source asserted
    output logic [3:0] key_pins, // pins 5..2, pulled up when open
    output logic rel_pin // release pin level
);
    // an open switch leaves the pull-up, a closed one pulls low
    // pins are plain digital inputs here, never a converter channel
    assign #(SETTLE_NS) key_pins = ~press;
    // the release pin idles low unless a scenario raises it
    assign #(SETTLE_NS) rel_pin = rel_on;
endmodule : kwhr_keys
`default_nettype wire

// file: sim/test_key_wakeup_halt_release.sv
// self-checking testbench of the key wakeup halt release block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %0t got %h expected %h", $time, g, e); end end
module test_key_wakeup_halt_release;
    // ****************************************
    // signals and expectations
    // ****************************************
    localparam logic [7:0] A_EN = kwhr_pkg::KEY_WAKE_ENABLE_ADDR;
    localparam logic [7:0] A_PORT = kwhr_pkg::KEY_PORT_DATA_ADDR;
    localparam logic [7:0] A_CTRL = kwhr_pkg::HALT_CTRL_ADDR;
    localparam logic [7:0] A_STAT = kwhr_pkg::HALT_STAT_ADDR;
    localparam logic [7:0] S_HALT = 8'h01 << kwhr_pkg::STAT_HALT_BIT;
    localparam logic [7:0] S_WARM = 8'h01 << kwhr_pkg::STAT_WARM_BIT;
    localparam logic [7:0] C_LVL = 8'h01 << kwhr_pkg::CTRL_LEVEL_BIT;
    localparam logic [7:0] C_HALT = 8'h01 << kwhr_pkg::CTRL_HALT_BIT;
    logic CLK_SYS = 1'b0; // 50 MHz clock
    logic SYS_RST, WR, RD, rel_on, HALTED, WARMING, WAKE_REQ, REL_PIN;
    logic rd_seen = 1'b0; // a read was taken, data stands now
    logic [7:0] ADDR, WDATA, RDATA, exp_v;
    logic [3:0] press, KEY_PINS, en;
    logic [7:0] exp_q[$]; // expected read data, oldest first
    int mismatches = 0, comparisons = 0, cycles = 0, k;
    kwhr_top #(.WARM_CYCLES(4)) uut (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .REL_PIN(REL_PIN),
        .KEY_PINS(KEY_PINS), .HALTED(HALTED), .WARMING(WARMING), .WAKE_REQ(WAKE_REQ));
    kwhr_keys keys (.press(press), .rel_on(rel_on), .key_pins(KEY_PINS), .rel_pin(REL_PIN));
    // ****************************************
    // clock, watchdog and read monitor
    // ****************************************
    always #10 CLK_SYS = ~CLK_SYS;
    // the run needs well under 1000 cycles, so 4000 means a hang
    always @(posedge CLK_SYS) begin
        rd_seen <= RD;
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            finish_test();
        end
    end
    // read data stands one cycle only, so look mid-cycle
    always @(negedge CLK_SYS) begin
        if (rd_seen) begin
            exp_v = exp_q.pop_front();
            `CHK(RDATA, exp_v)
        end
    end
    // ****************************************
    // bus tasks, each leaves one idle cycle so strobes never double up
    // ****************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK_SYS);
        WR <= 1'b0;
        @(posedge CLK_SYS);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        ADDR <= a;
        RD <= 1'b1;
        exp_q.push_back(e);
        @(posedge CLK_SYS);
        RD <= 1'b0;
        @(posedge CLK_SYS);
    endtask : rd
    // warm-up is 4 cycles here; 8 leaves margin before the next step
    task automatic settle();
        repeat (8) @(posedge CLK_SYS);
    endtask : settle
    task automatic finish_test();
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        SYS_RST = 1'b1;
        {WR, RD, rel_on} = 3'b000;
        {ADDR, WDATA} = 16'h0000;
        press = 4'h0;
        k = $urandom(35500);
        repeat (4) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        @(posedge CLK_SYS);
        // reset values, read-only and unmapped places; a low key never halts
        press <= 4'h5;
        rd(A_EN, 8'h00);
        rd(A_CTRL, 8'h00);
        rd(A_PORT, 8'h0a);
        wr(A_STAT, 8'hff);
        rd(A_STAT, 8'h00);
        rd(8'h00, 8'h00);
        press <= 4'h0;
        wr(A_CTRL, C_LVL);
        rd(A_CTRL, C_LVL);
        // each key alone: disabled keys pressed first must not wake
        for (k = 0; k < 4; k++) begin
            en = 4'h1 << k;
            wr(A_EN, {en, 4'($urandom())});
            rd(A_PORT, 8'h0f);
            wr(A_CTRL, C_LVL | C_HALT);
            press <= ~en;
            #1 `CHK(WAKE_REQ, 1'b0)
            `CHK(HALTED, 1'b1)
            repeat (2) @(posedge CLK_SYS);
            rd(A_STAT, S_HALT);
            press <= 4'hf;
            #1 `CHK(WAKE_REQ, 1'b1)
            @(posedge CLK_SYS);
            press <= 4'h0;
            rd(A_STAT, S_WARM);
            #1 `CHK(WARMING, 1'b1)
            settle();
            rd(A_STAT, 8'h00);
        end
        // pending release at entry skips the halt, key then pin
        wr(A_EN, 8'hf0);
        press <= 4'h8;
        wr(A_CTRL, C_LVL | C_HALT);
        rd(A_STAT, S_WARM);
        press <= 4'h0;
        rel_on <= 1'b1;
        settle();
        wr(A_CTRL, C_LVL | C_HALT);
        rd(A_STAT, S_WARM);
        rel_on <= 1'b0;
        settle();
        // edge style with the keys disabled: only a rising release pin wakes
        wr(A_CTRL, 8'h00);
        wr(A_EN, 8'h00);
        wr(A_CTRL, C_HALT);
        press <= 4'hf;
        repeat (2) @(posedge CLK_SYS);
        rd(A_STAT, S_HALT);
        press <= 4'h0;
        rel_on <= 1'b1;
        @(posedge CLK_SYS);
        rd(A_STAT, S_WARM);
        rel_on <= 1'b0;
        settle();
        // edge style still skips the halt on an enabled low key
        wr(A_EN, 8'hf0);
        press <= 4'h1;
        wr(A_CTRL, C_HALT);
        rd(A_STAT, S_WARM);
        press <= 4'h0;
        settle();
        rd(A_STAT, 8'h00);
        // reset in mid-run clears the enables and the style
        SYS_RST <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        @(posedge CLK_SYS);
        rd(A_CTRL, 8'h00);
        press <= 4'hf;
        wr(A_CTRL, C_LVL | C_HALT);
        rd(A_STAT, S_HALT);
        rel_on <= 1'b1;
        @(posedge CLK_SYS);
        rel_on <= 1'b0;
        press <= 4'h0;
        rd(A_STAT, S_WARM);
        settle();
        finish_test();
    end
endmodule : test_key_wakeup_halt_release
`default_nettype wire
